// file: caie_defs.vh
// Constants shared by the instruction execution unit
`ifndef CAIE_DEFS_VH
`define CAIE_DEFS_VH
// ****************************************
// Prefix bytes
// ****************************************
`define CAIE_PFX_CB      8'hcb
`define CAIE_PFX_ED      8'hed
`define CAIE_PFX_IDX1    8'hdd
`define CAIE_PFX_IDX2    8'hfd
// ****************************************
// Opcodes
// ****************************************
`define CAIE_OP_DECADJ   8'h27
`define CAIE_OP_INVERT   8'h2f
`define CAIE_OP_CFLIP    8'h3f
`define CAIE_OP_CFORCE   8'h37
`define CAIE_OP_MASK     8'hf3
`define CAIE_OP_UNMASK   8'hfb
`define CAIE_OP_NEGATE   8'h44
`define CAIE_OP_STYLE0   8'h46
`define CAIE_OP_STYLE1   8'h56
`define CAIE_OP_STYLE2   8'h5e
`define CAIE_OP_DROTL    8'h6f
`define CAIE_OP_DROTR    8'h67
`define CAIE_OP_SUP      8'ha1
`define CAIE_OP_SUPR     8'hb1
`define CAIE_OP_SDN      8'ha9
`define CAIE_OP_SDNR     8'hb9
// ****************************************
// Field codes
// ****************************************
`define CAIE_ALU_ADD     3'h0
`define CAIE_ALU_ADC     3'h1
`define CAIE_ALU_SUB     3'h2
`define CAIE_ALU_SUBB    3'h3
`define CAIE_ALU_AND     3'h4
`define CAIE_ALU_XOR     3'h5
`define CAIE_ALU_OR      3'h6
`define CAIE_ALU_CMP     3'h7
`define CAIE_FLD_MEM     3'h6
`define CAIE_FLD_ACC     3'h7
`define CAIE_CB_ROT      2'h0
`define CAIE_CB_TEST     2'h1
`define CAIE_CB_CLR      2'h2
`define CAIE_SS_DEST     2'h2
`define CAIE_SS_STACK    2'h3
// ****************************************
// Register pair indices
// ****************************************
`define CAIE_PR_COUNT    3'h0
`define CAIE_PR_POINT    3'h2
`define CAIE_PR_STACK    3'h3
`define CAIE_PR_IDX1     3'h4
`define CAIE_PR_IDX2     3'h5
// ****************************************
// Clock-state counts (one clk per state)
// ****************************************
`define CAIE_T_SHORT     5'h04
`define CAIE_T_MEM       5'h07
`define CAIE_T_ED        5'h08
`define CAIE_T_CBREG     5'h08
`define CAIE_T_INCMEM    5'h0b
`define CAIE_T_ADD16     5'h0b
`define CAIE_T_TESTMEM   5'h0c
`define CAIE_T_CBMEM     5'h0f
`define CAIE_T_W16       5'h0f
`define CAIE_T_SLAST     5'h10
`define CAIE_T_DIGIT     5'h12
`define CAIE_T_IDXALU    5'h13
`define CAIE_T_IDXTEST   5'h14
`define CAIE_T_SLOOP     5'h15
`define CAIE_T_IDXMOD    5'h17
// ****************************************
// Reset values
// ****************************************
`define CAIE_ACC_RST     8'h00
`define CAIE_FLAG_RST    8'h00
`define CAIE_STYLE_RST   2'h0
`endif

// file: caie_exec.v
// Instruction execution unit: ALU, shifts, bits, search, CPU control
`timescale 1ns/10ps
`include "caie_defs.vh"
// ****************************************
// ****************************************
module caie_exec
(
	input  wire        clk,
	input  wire        reset,
	input  wire        clkEn,
	input  wire        instValid,
	input  wire [7:0]  instPrefix,
	input  wire        instCb,
	input  wire [7:0]  instOp,
	input  wire [7:0]  instData,
	input  wire        memValid,
	input  wire [7:0]  memData,
	input  wire        pairLoadEn,
	input  wire [2:0]  pairLoadSel,
	input  wire [15:0] pairLoadData,
	input  wire        accLoadEn,
	input  wire [7:0]  accLoadData,
	input  wire [7:0]  flagLoadData,
	output reg         busy_q,
	output reg         done_q,
	output reg         noSample_q,
	output reg  [7:0]  acc_q,
	output reg  [7:0]  flags_q,
	output reg         intLatch_q,
	output reg  [1:0]  intStyle_q,
	output reg         memRead_q,
	output reg  [15:0] memAddr_q,
	output reg         memWrEn_q,
	output reg  [7:0]  memWrData_q,
	output reg         regWeA_q,
	output reg  [2:0]  regWaA_q,
	output reg  [15:0] regWdA_q,
	output reg         regWeB_q,
	output reg  [2:0]  regWaB_q,
	output reg  [15:0] regWdB_q
);
	// ****************************************
	// States
	// ****************************************
	localparam S_IDLE = 5'h01;  // Waiting for an instruction
	localparam S_READ = 5'h02;  // Pair read issued
	localparam S_MEMRD = 5'h04; // Fetching byte at pointer pair
	localparam S_EXEC = 5'h08;  // Result computed and stored
	localparam S_WAIT = 5'h10;  // Counting out clock states

	reg [4:0]  state_q;   // One-hot state
	reg [7:0]  pre_q;     // Latched prefix
	reg        cb_q;      // Index form carries a CB byte
	reg [7:0]  op_q;      // Latched opcode
	reg [7:0]  dat_q;     // Immediate or memory operand
	reg [7:0]  md_q;      // Byte read at pointer pair
	reg [4:0]  cnt_q;     // Remaining wait cycles
	reg        again_q;   // Another search pass follows
	reg        nos_q;     // Suppress sampling at the end
	wire [15:0] rdA;      // Pair from read port A
	wire [15:0] rdB;      // Pair from read port B

	// ****************************************
	// Helper functions
	// ****************************************
	// Even number of ones gives one
	function par;
		input [7:0] x;
		par = ~^x;
	endfunction

	// 8-bit ALU: {flags, result}, bits 5 and 3 kept
	function [15:0] alu8;
		input [2:0] k;
		input [7:0] a;
		input [7:0] b;
		input [7:0] f;
		reg       sub;
		reg       ci;
		reg [7:0] bb;
		reg [8:0] s;
		reg [4:0] h;
		reg [7:0] r;
		reg       hc;
		reg       cc;
		reg       pv;
		begin
			sub = (k == `CAIE_ALU_SUB) | (k == `CAIE_ALU_SUBB) |
				(k == `CAIE_ALU_CMP);
			ci = ((k == `CAIE_ALU_ADC) | (k == `CAIE_ALU_SUBB)) & f[0];
			bb = sub ? ~b : b;
			s = {1'b0, a} + {1'b0, bb} + {8'h00, ci ^ sub};
			h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci ^ sub};
			hc = h[4] ^ sub;
			cc = s[8] ^ sub;
			pv = (a[7] == bb[7]) & (s[7] != a[7]);
			r = s[7:0];
			case (k)
				`CAIE_ALU_AND:
				begin
					r = a & b;
					hc = 1'b1;
					cc = 1'b0;
					pv = par(r);
				end
				`CAIE_ALU_XOR:
				begin
					r = a ^ b;
					hc = 1'b0;
					cc = 1'b0;
					pv = par(r);
				end
				`CAIE_ALU_OR:
				begin
					r = a | b;
					hc = 1'b0;
					cc = 1'b0;
					pv = par(r);
				end
				default:
					r = s[7:0];
			endcase
			alu8 = {r[7], r == 8'h00, f[5], hc, f[3], pv, sub, cc, r};
		end
	endfunction

	// Rotate or shift: {carry out, result}
	function [8:0] rot8;
		input [2:0] k;
		input [7:0] x;
		input       c;
		begin
			case (k)
				3'h0: rot8 = {x[7], x[6:0], x[7]};
				3'h1: rot8 = {x[0], x[0], x[7:1]};
				3'h2: rot8 = {x[7], x[6:0], c};
				3'h3: rot8 = {x[0], c, x[7:1]};
				3'h4: rot8 = {x[7], x[6:0], 1'b0};
				3'h5: rot8 = {x[0], x[7], x[7:1]};
				3'h6: rot8 = {x[7], x[6:0], 1'b1};
				default: rot8 = {x[0], 1'b0, x[7:1]};
			endcase
		end
	endfunction

	// Pick an 8-bit operand by register field
	function [7:0] sel8;
		input [2:0]  code;
		input [15:0] pair;
		input [7:0]  acc;
		input [7:0]  dat;
		begin
			case (code)
				`CAIE_FLD_MEM: sel8 = dat;
				`CAIE_FLD_ACC: sel8 = acc;
				default: sel8 = code[0] ? pair[7:0] : pair[15:8];
			endcase
		end
	endfunction

	// ****************************************
	// Decode of the latched instruction
	// ****************************************
	wire ed = pre_q == `CAIE_PFX_ED;
	wire idxm = (pre_q == `CAIE_PFX_IDX1) | (pre_q == `CAIE_PFX_IDX2);
	wire cbx = (pre_q == `CAIE_PFX_CB) | cb_q;
	wire plain = ~ed & ~cbx;
	wire [2:0] idx = (pre_q == `CAIE_PFX_IDX2) ? `CAIE_PR_IDX2 :
		`CAIE_PR_IDX1;
	wire isSrch = ed & ((op_q == `CAIE_OP_SUP) | (op_q == `CAIE_OP_SUPR) |
		(op_q == `CAIE_OP_SDN) | (op_q == `CAIE_OP_SDNR));
	wire isDig = ed & ((op_q == `CAIE_OP_DROTL) | (op_q == `CAIE_OP_DROTR));
	wire isW16 = ed & (op_q[7:6] == 2'h1) & (op_q[2:0] == 3'h2);
	wire isAdd16 = plain & (op_q[7:6] == 2'h0) & (op_q[3:0] == 4'h9);
	wire isIncDec = plain & (op_q[7:6] == 2'h0) & (op_q[2:1] == 2'h2);
	wire isAlu = plain & ((op_q[7:6] == 2'h2) |
		((op_q[7:6] == 2'h3) & (op_q[2:0] == `CAIE_FLD_MEM)));
	wire isRotA = plain & (op_q[7:5] == 3'h0) & (op_q[2:0] == 3'h7);
	wire isStyle = ed & ((op_q == `CAIE_OP_STYLE0) |
		(op_q == `CAIE_OP_STYLE1) | (op_q == `CAIE_OP_STYLE2));
	wire isIntOp = plain & ((op_q == `CAIE_OP_MASK) |
		(op_q == `CAIE_OP_UNMASK));
	wire needMem = isSrch | isDig;
	wire [2:0] src = isIncDec ? op_q[5:3] : op_q[2:0];
	wire memOp = src == `CAIE_FLD_MEM;

	// Read port A: destination or operand pair
	wire [2:0] raddrA = (isSrch | isDig | isW16) ? `CAIE_PR_POINT :
		isAdd16 ? (idxm ? idx : `CAIE_PR_POINT) : {1'b0, src[2:1]};
	// Read port B: count pair or 16-bit source
	wire [2:0] raddrB = isSrch ? `CAIE_PR_COUNT :
		(op_q[5:4] == `CAIE_SS_DEST) ? raddrA :
		(op_q[5:4] == `CAIE_SS_STACK) ? `CAIE_PR_STACK : {1'b0, op_q[5:4]};

	// ****************************************
	// Execution results
	// ****************************************
	reg [7:0]  m;      // 8-bit operand
	reg [7:0]  v;      // Modified operand
	reg        wrV;    // Write v back to its field
	reg [15:0] r;      // ALU output
	reg [8:0]  rotOut; // Rotate output
	reg [16:0] s17;    // 16-bit sum
	reg [15:0] cntDec; // Decremented count pair
	reg [7:0]  cor;    // Decimal correction
	reg [7:0]  nAcc;
	reg [7:0]  nF;
	reg        nInt;
	reg [1:0]  nStyle;
	reg        weA;
	reg [15:0] wdA;
	reg        weB;
	reg [15:0] wdB;
	reg        mWe;
	reg [7:0]  mWd;
	reg [4:0]  t;
	reg        rep;

	// Combinational datapath for the EXEC state
	always @*
	begin
		m = sel8(src, rdA, acc_q, dat_q);
		v = m;
		wrV = 1'b0;
		r = 16'h0000;
		rotOut = 9'h000;
		s17 = 17'h00000;
		cntDec = rdB - 16'h0001;
		cor = 8'h00;
		nAcc = acc_q;
		nF = flags_q;
		nInt = intLatch_q;
		nStyle = intStyle_q;
		weA = 1'b0;
		wdA = rdA;
		weB = 1'b0;
		wdB = cntDec;
		mWe = 1'b0;
		mWd = 8'h00;
		t = `CAIE_T_SHORT;
		rep = 1'b0;
		if (isSrch)
		begin
			// Compare, step pointer, count down
			r = alu8(`CAIE_ALU_CMP, acc_q, md_q, flags_q);
			nF = {r[15:11], cntDec != 16'h0000, 1'b1, flags_q[0]};
			weA = 1'b1;
			wdA = op_q[3] ? rdA - 16'h0001 : rdA + 16'h0001;
			weB = 1'b1;
			rep = op_q[4] & (cntDec != 16'h0000) & ~r[14];
			t = rep ? `CAIE_T_SLOOP : `CAIE_T_SLAST;
		end
		else if (isDig)
		begin
			// Digit swap through the pointer byte
			if (op_q == `CAIE_OP_DROTL)
			begin
				mWd = {md_q[3:0], acc_q[3:0]};
				nAcc = {acc_q[7:4], md_q[7:4]};
			end
			else
			begin
				mWd = {acc_q[3:0], md_q[7:4]};
				nAcc = {acc_q[7:4], md_q[3:0]};
			end
			mWe = 1'b1;
			nF = {nAcc[7], nAcc == 8'h00, flags_q[5], 1'b0, flags_q[3],
				par(nAcc), 1'b0, flags_q[0]};
			t = `CAIE_T_DIGIT;
		end
		else if (isW16)
		begin
			// 16-bit add with carry or subtract with borrow
			if (op_q[3])
				s17 = {1'b0, rdA} + {1'b0, rdB} + {16'h0000, flags_q[0]};
			else
				s17 = {1'b0, rdA} - {1'b0, rdB} - {16'h0000, flags_q[0]};
			nF = {s17[15], s17[15:0] == 16'h0000, flags_q[5:3],
				((rdA[15] == rdB[15]) == op_q[3]) & (s17[15] != rdA[15]),
				~op_q[3], s17[16]};
			weA = 1'b1;
			wdA = s17[15:0];
			t = `CAIE_T_W16;
		end
		else if (isAdd16)
		begin
			// 16-bit add into pointer or index pair
			s17 = {1'b0, rdA} + {1'b0, rdB};
			nF = {flags_q[7:2], 1'b0, s17[16]};
			weA = 1'b1;
			wdA = s17[15:0];
			t = idxm ? `CAIE_T_W16 : `CAIE_T_ADD16;
		end
		else if (cbx)
		begin
			// Prefixed rotate, test, clear, set
			t = idxm ? `CAIE_T_IDXMOD : memOp ? `CAIE_T_CBMEM : `CAIE_T_CBREG;
			case (op_q[7:6])
				`CAIE_CB_ROT:
				begin
					rotOut = rot8(op_q[5:3], m, flags_q[0]);
					v = rotOut[7:0];
					wrV = 1'b1;
					nF = {v[7], v == 8'h00, flags_q[5], 1'b0, flags_q[3],
						par(v), 1'b0, rotOut[8]};
				end
				`CAIE_CB_TEST:
				begin
					nF = {flags_q[7], ~m[op_q[5:3]], flags_q[5], 1'b1,
						flags_q[3:2], 1'b0, flags_q[0]};
					t = idxm ? `CAIE_T_IDXTEST :
						memOp ? `CAIE_T_TESTMEM : `CAIE_T_CBREG;
				end
				`CAIE_CB_CLR:
				begin
					v = m & ~(8'h01 << op_q[5:3]);
					wrV = 1'b1;
				end
				default:
				begin
					v = m | (8'h01 << op_q[5:3]);
					wrV = 1'b1;
				end
			endcase
		end
		else if (isAlu)
		begin
			r = alu8(op_q[5:3], acc_q, m, flags_q);
			nF = r[15:8];
			if (op_q[5:3] != `CAIE_ALU_CMP)
				nAcc = r[7:0];
			t = idxm ? `CAIE_T_IDXALU : memOp ? `CAIE_T_MEM : `CAIE_T_SHORT;
		end
		else if (isIncDec)
		begin
			// Low field 101 counts down, 100 up
			r = alu8(op_q[0] ? `CAIE_ALU_SUB : `CAIE_ALU_ADD, m, 8'h01,
				flags_q);
			v = r[7:0];
			wrV = 1'b1;
			nF = {r[15:9], flags_q[0]};
			t = idxm ? `CAIE_T_IDXMOD : memOp ? `CAIE_T_INCMEM : `CAIE_T_SHORT;
		end
		else if (isRotA)
		begin
			rotOut = rot8(op_q[5:3], acc_q, flags_q[0]);
			nAcc = rotOut[7:0];
			nF = {flags_q[7:5], 1'b0, flags_q[3:2], 1'b0, rotOut[8]};
		end
		else if (ed & (op_q == `CAIE_OP_NEGATE))
		begin
			r = alu8(`CAIE_ALU_SUB, 8'h00, acc_q, flags_q);
			nAcc = r[7:0];
			nF = r[15:8];
			t = `CAIE_T_ED;
		end
		else if (isStyle)
		begin
			nStyle = op_q[4] ? (op_q[3] ? 2'h2 : 2'h1) : 2'h0;
			t = `CAIE_T_ED;
		end
		else if (plain)
		begin
			case (op_q)
				`CAIE_OP_DECADJ:
				begin
					// Correction per nibble, then add or subtract
					cor = {(flags_q[0] | (acc_q > 8'h99)) ? 4'h6 : 4'h0,
						(flags_q[4] | (acc_q[3:0] > 4'h9)) ? 4'h6 : 4'h0};
					nAcc = flags_q[1] ? acc_q - cor : acc_q + cor;
					nF = {nAcc[7], nAcc == 8'h00, flags_q[5],
						flags_q[1] ? (flags_q[4] & (acc_q[3:0] < 4'h6)) :
						(acc_q[3:0] > 4'h9), flags_q[3], par(nAcc),
						flags_q[1], flags_q[0] | (acc_q > 8'h99)};
				end
				`CAIE_OP_INVERT:
				begin
					nAcc = ~acc_q;
					nF = {flags_q[7:5], 1'b1, flags_q[3:2], 1'b1,
						flags_q[0]};
				end
				`CAIE_OP_CFLIP:
					nF = {flags_q[7:5], flags_q[0], flags_q[3:2], 1'b0,
						~flags_q[0]};
				`CAIE_OP_CFORCE:
					nF = {flags_q[7:5], 1'b0, flags_q[3:2], 2'h1};
				`CAIE_OP_MASK:
					nInt = 1'b0;
				`CAIE_OP_UNMASK:
					nInt = 1'b1;
				default:
					nInt = intLatch_q;
			endcase
		end
		// Store a modified byte where it came from
		if (wrV)
		begin
			if (src == `CAIE_FLD_ACC)
				nAcc = v;
			else if (memOp)
			begin
				mWe = 1'b1;
				mWd = v;
			end
			else
			begin
				weA = 1'b1;
				wdA = src[0] ? {rdA[15:8], v} : {v, rdA[7:0]};
			end
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= S_IDLE;
			pre_q <= 8'h00;
			cb_q <= 1'b0;
			op_q <= 8'h00;
			dat_q <= 8'h00;
			md_q <= 8'h00;
			cnt_q <= 5'h00;
			again_q <= 1'b0;
			nos_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			noSample_q <= 1'b0;
			acc_q <= `CAIE_ACC_RST;
			flags_q <= `CAIE_FLAG_RST;
			intLatch_q <= 1'b0;
			intStyle_q <= `CAIE_STYLE_RST;
			memRead_q <= 1'b0;
			memAddr_q <= 16'h0000;
			memWrEn_q <= 1'b0;
			memWrData_q <= 8'h00;
			regWeA_q <= 1'b0;
			regWaA_q <= 3'h0;
			regWdA_q <= 16'h0000;
			regWeB_q <= 1'b0;
			regWaB_q <= 3'h0;
			regWdB_q <= 16'h0000;
		end
		else if (clkEn)
		begin
			// Pulses default low
			done_q <= 1'b0;
			noSample_q <= 1'b0;
			memWrEn_q <= 1'b0;
			regWeA_q <= 1'b0;
			regWeB_q <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					if (instValid)
					begin
						// Accept an instruction
						pre_q <= instPrefix;
						cb_q <= instCb;
						op_q <= instOp;
						dat_q <= instData;
						busy_q <= 1'b1;
						state_q <= S_READ;
					end
					else
					begin
						// Preload from the surrounding core
						regWeA_q <= pairLoadEn;
						regWaA_q <= pairLoadSel;
						regWdA_q <= pairLoadData;
						if (accLoadEn)
						begin
							acc_q <= accLoadData;
							flags_q <= flagLoadData;
						end
					end
				end
				S_READ:
					state_q <= needMem ? S_MEMRD : S_EXEC;
				S_MEMRD:
				begin
					// Request the byte at the pointer pair
					if (~memRead_q)
					begin
						memRead_q <= 1'b1;
						memAddr_q <= rdA;
					end
					else if (memValid)
					begin
						memRead_q <= 1'b0;
						md_q <= memData;
						state_q <= S_EXEC;
					end
				end
				S_EXEC:
				begin
					acc_q <= nAcc;
					flags_q <= nF;
					intLatch_q <= nInt;
					intStyle_q <= nStyle;
					regWeA_q <= weA;
					regWaA_q <= raddrA;
					regWdA_q <= wdA;
					regWeB_q <= weB;
					regWaB_q <= raddrB;
					regWdB_q <= wdB;
					memWrEn_q <= mWe;
					memWrData_q <= mWd;
					cnt_q <= t - 5'h02;
					again_q <= rep;
					nos_q <= isIntOp;
					state_q <= S_WAIT;
				end
				S_WAIT:
				begin
					// Finish, or start the next search pass, after the clock-state count
					if (cnt_q == 5'h00)
					begin
						if (again_q)
							state_q <= S_READ;
						else
						begin
							done_q <= 1'b1;
							busy_q <= 1'b0;
							noSample_q <= nos_q;
							state_q <= S_IDLE;
						end
					end
					else
						cnt_q <= cnt_q - 5'h01;
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// Register pairs
	// ****************************************
	caie_regmem uRegs
	(
		.clk       (clk),
		.reset     (reset),
		.clkEn     (clkEn),
		.rdAddrA   (raddrA),
		.rdAddrB   (raddrB),
		.wrEnA     (regWeA_q),
		.wrAddrA   (regWaA_q),
		.wrDataA   (regWdA_q),
		.wrEnB     (regWeB_q),
		.wrAddrB   (regWaB_q),
		.wrDataB   (regWdB_q),
		.rdDataA_q (rdA),
		.rdDataB_q (rdB)
	);
endmodule

// file: caie_exec_chk.sv
// Port checker for the instruction execution unit
`timescale 1ns/10ps
module caie_exec_chk
(
	input wire        clk,
	input wire        reset,
	input wire        clkEn,
	input wire        instValid,
	input wire [7:0]  instPrefix,
	input wire [7:0]  instOp,
	input wire        memValid,
	input wire        busy_q,
	input wire        done_q,
	input wire        noSample_q,
	input wire [7:0]  acc_q,
	input wire [7:0]  flags_q,
	input wire        memRead_q,
	input wire        regWeB_q,
	input wire [15:0] regWdB_q
);
	// ****************************************
	// Request decode
	// ****************************************
	wire take = clkEn && instValid && !busy_q; // Accepted request
	wire inv  = take && instPrefix == 8'h00 && instOp == 8'h2f; // Invert
	wire ed   = take && instPrefix == 8'hed; // ED-prefixed request
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ****************************************
	// Properties
	// ****************************************
	a_done_single: assert property (done_q |=> !done_q)
		else $error("done wider than one cycle");
	a_nosample_done: assert property (noSample_q |-> done_q)
		else $error("no-sample pulse without done");
	a_invert_acc: assert property (inv |-> ##3
		acc_q == ~$past(acc_q, 3) && flags_q[4] && flags_q[1])
		else $error("invert result wrong");
	a_invert_time: assert property (inv |=> !done_q[*5] ##1 done_q)
		else $error("invert took wrong time");
	a_ed_time: assert property (ed && (instOp == 8'h44 ||
		instOp == 8'h46 || instOp == 8'h56 || instOp == 8'h5e) |=>
		##1 !done_q[*8] ##1 done_q)
		else $error("prefixed op took wrong time");
	a_negate_acc: assert property (ed && instOp == 8'h44 |-> ##3
		acc_q == 8'h00 - $past(acc_q, 3) && flags_q[1])
		else $error("negate result wrong");
	a_search_flags: assert property (regWeB_q |-> flags_q[1] &&
		flags_q[2] == (regWdB_q != 16'h0000))
		else $error("search flags wrong");
	a_memrd_hold: assert property (memRead_q && !memValid |=>
		memRead_q)
		else $error("memory request dropped early");
endmodule
bind caie_exec caie_exec_chk caie_exec_chk_inst(.clk, .reset, .clkEn,
	.instValid, .instPrefix, .instOp, .memValid, .busy_q, .done_q,
	.noSample_q, .acc_q, .flags_q, .memRead_q, .regWeB_q, .regWdB_q);

// file: caie_exec_tb.sv
// Self-checking bench for the instruction execution unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module caie_exec_tb;
	logic clk = 0, reset = 1, clkEn = 1, instValid = 0, instCb = 0, memValid;
	logic [7:0] instPrefix = 0, instOp = 0, instData = 0, memData;
	logic pairLoadEn = 0, accLoadEn = 0, busy_q, done_q, noSample_q;
	logic [2:0] pairLoadSel = 0, lat = 0, regWaA_q, regWaB_q;
	logic [15:0] pairLoadData = 0, memAddr_q, regWdA_q, regWdB_q, e;
	logic [7:0] accLoadData = 0, flagLoadData = 0, acc_q, flags_q, memWrData_q;
	logic intLatch_q, memRead_q, memWrEn_q, regWeA_q, regWeB_q;
	logic [1:0] intStyle_q;
	logic [15:0] lastPtr, lastCnt;
	logic [7:0] lastWr, a, f, g, m;
	logic [8:0] r;
	int failures = 0, checkCount = 0, cyc, passes, ticks = 0;
	caie_exec caie_exec_inst(.clk, .reset, .clkEn, .instValid, .instPrefix,
		.instCb, .instOp, .instData, .memValid, .memData, .pairLoadEn,
		.pairLoadSel, .pairLoadData, .accLoadEn, .accLoadData, .flagLoadData,
		.busy_q, .done_q, .noSample_q, .acc_q, .flags_q, .intLatch_q,
		.intStyle_q, .memRead_q, .memAddr_q, .memWrEn_q, .memWrData_q,
		.regWeA_q, .regWaA_q, .regWdA_q, .regWeB_q, .regWaB_q, .regWdB_q);
	caie_mem_model caie_mem_model_inst(.clk, .lat, .memRead_q, .memAddr_q,
		.memValid, .memData);
	// Clock and hang guard
	initial forever #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		ticks++;
		if (ticks == 6000)
		begin
			failures++;
			print_verdict;
		end
	end
	// Capture pair and memory write pulses
	always @(posedge clk)
	begin
		if (regWeB_q) passes++;
		if (regWeB_q) lastCnt <= regWdB_q;
		if (regWeA_q) lastPtr <= regWdA_q;
		if (memWrEn_q) lastWr <= memWrData_q;
	end
	// Expected 8-bit arithmetic: flags over result
	function [15:0] alu(input [2:0] k, input [7:0] x, y, input ci);
		reg [8:0] s;
		reg c, h, v;
		begin
			c = (k == 1 || k == 3) & ci;
			s = k[1] ? x - y - c : x + y + c;
			h = k[1] ? x[3:0] < {1'b0, y[3:0]} + c : x[3:0] + y[3:0] + c > 15;
			v = ((x[7] ^ y[7]) == k[1]) && (s[7] ^ x[7]);
			alu = {s[7], s[7:0] == 0, 1'b0, h, 1'b0, v, k[1], s[8],
				k == 7 ? x : s[7:0]};
			if (k[2] && k != 7) s = k == 4 ? x & y : k == 5 ? x ^ y : x | y;
			if (k[2] && k != 7) alu = {s[7], s[7:0] == 0, 1'b0, k == 4, 1'b0,
				~^s[7:0], 2'b00, s[7:0]};
		end
	endfunction
	// Expected rotate or shift: carry out above result
	function [8:0] sh(input [2:0] k, input [7:0] v, input c);
		case (k)
			0: sh = {v[7], v[6:0], v[7]};
			1: sh = {v[0], v[0], v[7:1]};
			2: sh = {v[7], v[6:0], c};
			3: sh = {v[0], c, v[7:1]};
			4: sh = {v[7], v[6:0], 1'b0};
			5: sh = {v[0], v[7], v[7:1]};
			6: sh = {v[7], v[6:0], 1'b1};
			default: sh = {v[0], 1'b0, v[7:1]};
		endcase
	endfunction
	// Offer one instruction and wait for done
	task run(input [7:0] p, o, d);
		begin
			instPrefix = p;
			instOp = o;
			instData = d;
			instValid = 1;
			@(negedge clk);
			instValid = 0;
			cyc = 1;
			while (done_q !== 1'b1 && cyc < 300)
			begin
				@(negedge clk);
				cyc++;
			end
			if (done_q !== 1'b1)
				failures++;
		end
	endtask
	// Preload a pair
	task ld(input [2:0] s, input [15:0] d);
		begin
			pairLoadSel = s;
			pairLoadData = d;
			pairLoadEn = 1;
			@(negedge clk);
			pairLoadEn = 0;
			@(negedge clk);
		end
	endtask
	// Preload accumulator and flags
	task sa(input [7:0] av, fv);
		begin
			accLoadData = av;
			flagLoadData = fv;
			a = av;
			f = fv;
			accLoadEn = 1;
			@(negedge clk);
			accLoadEn = 0;
		end
	endtask
	// One search run against the memory responder
	task srch(input [7:0] op, input [15:0] cnt, input [7:0] av, input int np,
		input [15:0] ep, ec, input [7:0] ef);
		begin
			ld(0, cnt);
			ld(2, 16'h1000);
			sa(av, 8'h00);
			passes = 0;
			lat = 3'($urandom);
			run(8'hed, op, 0);
			`CHK("search passes", np, passes)
			`CHK("search pairs", {ep, ec}, {lastPtr, lastCnt})
			`CHK("search flags", ef, flags_q & 8'h46)
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d failures %0d", checkCount, failures);
			if (failures == 0 && checkCount > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		void'($urandom(11));
		repeat (16) @(negedge clk);
		reset = 0;
		for (int i = 0; i < 40; i++)
		begin
			sa(8'($urandom), 8'($urandom));
			g = 8'($urandom);
			run(0, {2'b11, i[2:0], 3'b110}, g);
			e = alu(i[2:0], a, g, f[0]);
			`CHK("alu", e, {flags_q & 8'hd7, acc_q})
			`CHK("alu time", 9, cyc)
		end
		sa(8'h3c, 8'h29);
		run(0, 8'h2f, 0);
		`CHK("invert", 16'hc313, {acc_q, flags_q & 8'hd7})
		for (int i = 0; i < 4; i++)
		begin
			sa(i == 0 ? 8'h80 : i == 1 ? 8'h00 : 8'($urandom), 8'h00);
			run(8'hed, 8'h44, 0);
			`CHK("negate", alu(2, 0, a, 0), {flags_q & 8'hd7, acc_q})
		end
		sa(8'h7f, 8'h01);
		run(0, 8'h3c, 0);
		`CHK("inc", 16'h8095, {acc_q, flags_q & 8'hd7})
		run(0, 8'h3d, 0);
		`CHK("dec", 16'h7f17, {acc_q, flags_q & 8'hd7})
		sa(8'h15, 8'h00);
		run(0, 8'hc6, 8'h27);
		run(0, 8'h27, 0);
		`CHK("decimal adjust", 16'h4214, {acc_q, flags_q & 8'hd7})
		run(0, 8'hfb, 0);
		`CHK("unmask", 2'b11, {intLatch_q, noSample_q})
		run(0, 8'hf3, 0);
		`CHK("mask", 2'b01, {intLatch_q, noSample_q})
		for (int i = 0; i < 3; i++)
		begin
			run(8'hed, i == 0 ? 8'h5e : i == 1 ? 8'h56 : 8'h46, 0);
			`CHK("style", 2'(2 - i), intStyle_q)
		end
		for (int i = 0; i < 12; i++)
		begin
			sa(8'($urandom), 8'($urandom));
			run(i < 4 ? 8'h00 : 8'hcb, {2'h0, i[2:0], 3'h7}, 0);
			r = sh(i[2:0], a, f[0]);
			if (i < 4)
				`CHK("acc rotate", {f & 8'hc4 | r[8], r[7:0]}, {flags_q & 8'hd7, acc_q})
			else
				`CHK("shift", {r[7], r[7:0] == 0, 3'h0, ~^r[7:0], 1'b0, r}, {flags_q & 8'hd7, acc_q})
		end
		for (int i = 0; i < 8; i++)
		begin
			sa(8'($urandom), 8'($urandom));
			run(8'hcb, {2'b01, i[2:0], 3'b111}, 0);
			`CHK("bit test", ~a[i], flags_q[6])
			run(8'hcb, {2'b11, i[2:0], 3'b111}, 0);
			`CHK("bit set", a | (8'h01 << i), acc_q)
			g = flags_q;
			run(8'hcb, {2'b10, i[2:0], 3'b111}, 0);
			`CHK("bit clear", {a & ~(8'h01 << i), g}, {acc_q, flags_q})
		end
		ld(2, 16'h2033);
		m = 8'h33 ^ 8'h5a;
		for (int i = 0; i < 2; i++)
		begin
			sa(8'($urandom), 8'h00);
			lat = 3'($urandom);
			run(8'hed, i ? 8'h67 : 8'h6f, 0);
			e = i ? {a[7:4], m[3:0], a[3:0], m[7:4]} : {a[7:4], m[7:4], m[3:0], a[3:0]};
			`CHK("digit", e, {acc_q, lastWr})
			`CHK("digit parity", ~^e[15:8], flags_q[2])
		end
		srch(8'hb1, 16'h0005, 8'h58, 3, 16'h1003, 16'h0002, 8'h46);
		srch(8'ha9, 16'h0001, 8'h00, 1, 16'h0fff, 16'h0000, 8'h02);
		srch(8'hb9, 16'h0003, 8'h00, 3, 16'h0ffd, 16'h0000, 8'h02);
		srch(8'ha1, 16'h0000, 8'h5a, 1, 16'h1001, 16'hffff, 8'h46);
		print_verdict;
	end
endmodule

// file: caie_mem_model.sv
// Fetch-side memory responder with adjustable latency
`timescale 1ns/10ps
module caie_mem_model
(
	input  wire        clk,
	input  wire [2:0]  lat,
	input  wire        memRead_q,
	input  wire [15:0] memAddr_q,
	output reg         memValid,
	output reg  [7:0]  memData
);
	reg [2:0] wait_q = 3'h0; // Cycles waited so far
	initial memValid = 1'b0;
	initial memData = 8'h00;
	// Answer after lat cycles; data toggles while not valid
	always @(posedge clk)
	begin
		memValid <= 1'b0;
		memData <= ~memData;
		wait_q <= 3'h0;
		if (memRead_q && !memValid && wait_q == lat)
		begin
			memValid <= 1'b1;
			memData <= memAddr_q[7:0] ^ 8'h5a;
		end
		else if (memRead_q && !memValid)
			wait_q <= wait_q + 3'h1;
	end
endmodule

// file: caie_placeholder_none.v
// Spare design file; holds no module
`timescale 1ns/10ps

// file: caie_regmem.v
// Register pair memory with two registered read and two write ports
`timescale 1ns/10ps
module caie_regmem
(
	input  wire        clk,
	input  wire        reset,
	input  wire        clkEn,
	input  wire [2:0]  rdAddrA,
	input  wire [2:0]  rdAddrB,
	input  wire        wrEnA,
	input  wire [2:0]  wrAddrA,
	input  wire [15:0] wrDataA,
	input  wire        wrEnB,
	input  wire [2:0]  wrAddrB,
	input  wire [15:0] wrDataB,
	output reg  [15:0] rdDataA_q,
	output reg  [15:0] rdDataB_q
);
	// ****************************************
	// Storage
	// ****************************************
	reg [15:0] mem [0:7];   // Pair contents, no reset

	// Writes; port B wins a same-address clash
	always @(posedge clk)
	begin
		if (clkEn)
		begin
			if (wrEnA)
				mem[wrAddrA] <= wrDataA;
			if (wrEnB)
				mem[wrAddrB] <= wrDataB;
		end
	end

	// Registered reads
	always @(posedge clk)
	begin
		if (reset)
		begin
			rdDataA_q <= 16'h0000;
			rdDataB_q <= 16'h0000;
		end
		else if (clkEn)
		begin
			rdDataA_q <= mem[rdAddrA];
			rdDataB_q <= mem[rdAddrB];
		end
	end
endmodule
